/* File: rtl/ubm_consts.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  utility bus manager. Assumes a 100 MHz system clock.
*/
`ifndef UBM_CONSTS_SVH
`define UBM_CONSTS_SVH

`define UBM_ADR_MODE_SEL 16'h8006
`define UBM_ADR_PHY_RST 16'h8007
`define UBM_ADR_PIN_CTL 16'h801a

`define UBM_BIT_OVERRIDE 0
`define UBM_BIT_PHY_RST 0
`define UBM_BIT_STYLE 3

`define UBM_OVR_RST 1'h0
`define UBM_MODE_RST 4'h0
`define UBM_TAG_RST 10'h000

`define UBM_CLK_NS 10
`define UBM_STB_NS 40
`define UBM_STB_CYC ((`UBM_STB_NS + `UBM_CLK_NS - 1) / `UBM_CLK_NS)

`define UBM_STRAP_CYC 6'h10
`define UBM_TRI_CYC 6'h18
`define UBM_SEQ_DONE 6'h20
`define UBM_PHY_SW_CYC 5'h10

`endif

/* File: rtl/ubm_manager.sv */
/*
  Utility bus manager: runs PHY register reads and writes decoded from
  in-band programming cells, holds the pin override, mode select and PHY
  reset registers, captures straps after reset.
  Assumes a cell interpreter on clk_sys drives the command, byte and
  register ports, and pads resolve pins from the _out/_oe pairs.
  // Contract
  // [RQ1] Override bit resets zero, unlocks strapped registers
  // [RQ2] Management pins carry straps during reset
  // [RQ3] Utility bus or UTOPIA management, never both
  // [RQ4] Commands arrive in in-band cells
  // [RQ5] Twelve bus pins are chip selects 12..1
  // [RQ6] Management pin one is chip select 0
  // [RQ7] Byte bus multiplexes address and data
  // [RQ8] Pin two is active-low read strobe
  // [RQ9] Pin three is active-low write strobe
  // [RQ10] Pin five is active-high address latch enable
  // [RQ11] PHY reset low on sequence or bit
  // [RQ12] PHY drives interrupt; processor clears it
  // [RQ13] Read command drives select, latch, strobe, bus
  // [RQ14] PHY latches address on latch falling edge
  // [RQ15] Release byte bus once select and read low
  // [RQ16] PHY drives data until select/strobe rise
  // [RQ17] Read carries at most 32 bytes
  // [RQ18] Mode bit 3 selects management style
  // [RQ19] PHY reset bit holds reset 16 cycles
  // [RQ20] Write same as read, at most 32 bytes
  // [RQ21] Latch drops before strobe; select ends after
  // [RQ22] Unaddressed selects stay high
*/
`timescale 1ns/1ps
`include "ubm_consts.svh"
module ubm_manager
  import ubm_pkg::*;
#(
  parameter int STB_CYC = `UBM_STB_CYC
) (
  input logic clk_sys,
  input logic rst_n,
  input logic cmd_valid,
  output logic cmd_ready,
  input logic cmd_write,
  input logic [3:0] cmd_phy,
  input logic [7:0] cmd_reg_addr,
  input logic [4:0] cmd_len_m1,
  input logic [7:0] wr_data,
  input logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_last,
  output logic busy,
  input logic inband_reset,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_addr,
  input logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [3:0] mode_select,
  output logic [9:0] tag_straps,
  output logic phy_irq,
  input logic [11:0] management_bus_pins_in,
  output logic [11:0] management_bus_pins_out,
  output logic [11:0] management_bus_pins_oe,
  output logic management_pin_one_out,
  output logic management_pin_one_oe,
  input logic management_pin_two_in,
  output logic management_pin_two_out,
  output logic management_pin_two_oe,
  input logic management_pin_three_in,
  output logic management_pin_three_out,
  output logic management_pin_three_oe,
  output logic management_pin_five_out,
  output logic management_pin_five_oe,
  input logic [7:0] management_byte_bus_in,
  output logic [7:0] management_byte_bus_out,
  output logic [7:0] management_byte_bus_oe,
  output logic phy_reset_n,
  input logic phy_interrupt_n
);

  if (STB_CYC < 3 || STB_CYC > 15) begin : g_chk
    $error("ubm_manager: STB_CYC must lie in 3..15");
  end

  ubm_state_t st_q, st_d;
  logic [12:0] cs_q, cs_d;
  logic ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, drv_q, drv_d;
  logic wr_q, wr_d;
  logic [7:0] dout_q, dout_d, rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d, rd_last_q, rd_last_d;
  logic [4:0] len_q, len_d, idx_q, idx_d;
  logic [3:0] cnt_q, cnt_d;
  logic [5:0] seq_q, seq_d;
  logic ovr_q, ovr_d;
  logic [3:0] mode_q, mode_d;
  logic [9:0] tag_q, tag_d;
  logic [4:0] swc_q, swc_d;
  logic [7:0] rdata_q, rdata_d;
  logic [22:0] pin_s;
  logic pins_en, take;

  // Pins reach logic only through two flip-flops
  // Interrupt pin idles high; resetting to that level avoids a false irq
  ubm_sync #(.WIDTH(23), .RST_VAL(23'h400000)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({phy_interrupt_n, management_pin_three_in, management_pin_two_in,
        management_bus_pins_in, management_byte_bus_in}),
    .q(pin_s)
  );

  assign phy_irq = !pin_s[22]; // RQ12
  // Pins float during strap load; UTOPIA mode leaves them to its engine
  assign pins_en = (seq_q >= `UBM_TRI_CYC) && !mode_q[`UBM_BIT_STYLE]; // RQ2 RQ3 RQ18
  assign cmd_ready = (st_q == UBM_IDLE) && pins_en && !inband_reset; // RQ3 RQ4
  assign take = cmd_valid && cmd_ready;
  assign wr_ready = wr_q && (st_q == UBM_ADR || st_q == UBM_REC);
  assign busy = st_q != UBM_IDLE;

  always_comb begin
    st_d = st_q;
    cs_d = cs_q;
    ale_d = 1'b0;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    drv_d = drv_q;
    wr_d = wr_q;
    dout_d = dout_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    rd_last_d = 1'b0;
    len_d = len_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    unique case (st_q)
      UBM_IDLE: begin
        if (take) begin
          cs_d = 13'h1fff;
          if (cmd_phy <= 4'hc)
            cs_d[cmd_phy] = 1'b0; // RQ5 RQ6 RQ22
          ale_d = 1'b1; // RQ10 RQ13 RQ20
          drv_d = 1'b1;
          dout_d = cmd_reg_addr; // RQ7
          wr_d = cmd_write;
          len_d = cmd_len_m1; // RQ17 RQ20
          idx_d = 5'h00;
          st_d = UBM_ALE;
        end
      end
      UBM_ALE: st_d = UBM_ADR; // RQ14
      UBM_ADR, UBM_REC: begin
        cnt_d = 4'h0;
        if (wr_q) begin
          if (wr_valid) begin
            dout_d = wr_data;
            wr_n_d = 1'b0; // RQ9 RQ21
            st_d = UBM_STB;
          end
        end else begin
          rd_n_d = 1'b0; // RQ8 RQ21
          drv_d = 1'b0; // RQ15
          st_d = UBM_STB;
        end
      end
      UBM_STB: begin
        if (cnt_q == 4'(STB_CYC - 1)) begin
          if (!wr_q) begin
            rd_data_d = pin_s[7:0]; // RQ16
            rd_valid_d = 1'b1;
            rd_last_d = idx_q == len_q;
          end
          idx_d = idx_q + 5'h01;
          st_d = (idx_q == len_q) ? UBM_END : UBM_REC; // RQ17 RQ20
        end else begin
          cnt_d = cnt_q + 4'h1;
          rd_n_d = rd_n_q;
          wr_n_d = wr_n_q;
        end
      end
      UBM_END: begin
        cs_d = 13'h1fff; // RQ21
        drv_d = 1'b0;
        st_d = UBM_IDLE;
      end
      default: st_d = UBM_IDLE;
    endcase
    if (inband_reset) begin
      st_d = UBM_IDLE;
      cs_d = 13'h1fff;
      drv_d = 1'b0;
      rd_n_d = 1'b1;
      wr_n_d = 1'b1;
      ale_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= UBM_IDLE;
      cs_q <= 13'h1fff;
      ale_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      drv_q <= 1'b0;
      wr_q <= 1'b0;
      dout_q <= 8'h00;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      rd_last_q <= 1'b0;
      len_q <= 5'h00;
      idx_q <= 5'h00;
      cnt_q <= 4'h0;
    end else begin
      st_q <= st_d;
      cs_q <= cs_d;
      ale_q <= ale_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      drv_q <= drv_d;
      wr_q <= wr_d;
      dout_q <= dout_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_last_q <= rd_last_d;
      len_q <= len_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    seq_d = seq_q;
    ovr_d = ovr_q;
    mode_d = mode_q;
    tag_d = tag_q;
    swc_d = swc_q;
    rdata_d = 8'h00;
    if (seq_q < `UBM_SEQ_DONE)
      seq_d = seq_q + 6'h01;
    if (seq_q == `UBM_STRAP_CYC - 6'h01) begin
      mode_d = {pin_s[20], pin_s[19], pin_s[21], pin_s[18]}; // RQ2
      tag_d = pin_s[17:8]; // RQ2
    end
    if (swc_q != 5'h00)
      swc_d = swc_q - 5'h01; // RQ19
    if (reg_rd) begin
      unique case (reg_addr)
        `UBM_ADR_PIN_CTL: rdata_d[`UBM_BIT_OVERRIDE] = ovr_q;
        `UBM_ADR_MODE_SEL: rdata_d[3:0] = mode_q;
        `UBM_ADR_PHY_RST: rdata_d[`UBM_BIT_PHY_RST] = swc_q != 5'h00; // RQ19
        default: rdata_d = 8'h00;
      endcase
    end
    if (reg_wr && seq_q == `UBM_SEQ_DONE) begin
      unique case (reg_addr)
        `UBM_ADR_PIN_CTL: ovr_d = reg_wdata[`UBM_BIT_OVERRIDE]; // RQ1
        `UBM_ADR_MODE_SEL: if (ovr_q) mode_d = reg_wdata[3:0]; // RQ1 RQ18
        `UBM_ADR_PHY_RST:
          if (reg_wdata[`UBM_BIT_PHY_RST] && swc_q == 5'h00)
            swc_d = `UBM_PHY_SW_CYC; // RQ11 RQ19
        default: ;
      endcase
    end
    if (inband_reset)
      seq_d = 6'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_q <= 6'h00;
      ovr_q <= `UBM_OVR_RST; // RQ1
      mode_q <= `UBM_MODE_RST;
      tag_q <= `UBM_TAG_RST;
      swc_q <= 5'h00;
      rdata_q <= 8'h00;
    end else begin
      seq_q <= seq_d;
      ovr_q <= ovr_d;
      mode_q <= mode_d;
      tag_q <= tag_d;
      swc_q <= swc_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign mode_select = mode_q;
  assign tag_straps = tag_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_last = rd_last_q;
  assign management_bus_pins_out = cs_q[12:1]; // RQ5
  assign management_bus_pins_oe = {12{pins_en}};
  assign management_pin_one_out = cs_q[0]; // RQ6
  assign management_pin_one_oe = pins_en;
  assign management_pin_two_out = rd_n_q; // RQ8
  assign management_pin_two_oe = pins_en;
  assign management_pin_three_out = wr_n_q; // RQ9
  assign management_pin_three_oe = pins_en;
  assign management_pin_five_out = ale_q; // RQ10
  assign management_pin_five_oe = pins_en;
  assign management_byte_bus_out = dout_q; // RQ7
  assign management_byte_bus_oe = {8{pins_en && drv_q}}; // RQ15
  // Power-up PHY reset follows the float window, then the software pulse
  assign phy_reset_n = !((seq_q >= `UBM_TRI_CYC && seq_q < `UBM_SEQ_DONE)
                         || swc_q != 5'h00); // RQ11

  // Checks
  ovr_reset_a: assert property (@(posedge clk_sys) // RQ1
    rst_n && $past(!rst_n) |-> !ovr_q) else $error("override not zero");
  lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
    reg_wr && reg_addr == `UBM_ADR_MODE_SEL && !ovr_q && !inband_reset
    && seq_q == `UBM_SEQ_DONE |=> $stable(mode_q))
    else $error("locked mode changed");
  strap_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_q < `UBM_TRI_CYC |-> management_bus_pins_oe == 12'h000 // RQ2
    && !management_pin_two_oe) else $error("pins driven in strap time");
  style_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
    mode_q[`UBM_BIT_STYLE] |-> !cmd_ready && !management_pin_five_oe)
    else $error("utility bus active in UTOPIA mode");
  start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
    cmd_valid && cmd_ready && !cmd_write |=> ale_q && drv_q && rd_n_q
    && cs_q != 13'h1fff) else $error("read start wrong");
  ale_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
    $rose(ale_q) |-> rd_n_q && wr_n_q ##1 !ale_q ##1 !ale_q)
    else $error("latch enable not a clean pulse");
  release_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ15
    !rd_n_q && cs_q != 13'h1fff |-> management_byte_bus_oe == 8'h00)
    else $error("bus driven during read");
  one_cs_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ22
    $onehot0(~cs_q)) else $error("more than one select low");
  max_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ17
    busy && st_q != UBM_END |-> idx_q <= len_q)
    else $error("byte count overrun");
  sw_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ19
    reg_wr && reg_addr == `UBM_ADR_PHY_RST && reg_wdata[0] && swc_q == 5'h00
    && seq_q == `UBM_SEQ_DONE && !inband_reset
    |=> (!phy_reset_n) [*8] ##1 (!phy_reset_n) [*8] ##1 phy_reset_n)
    else $error("PHY reset pulse not 16 cycles");
  end_cs_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ21
    st_q == UBM_END |=> cs_q == 13'h1fff && rd_n_q && wr_n_q)
    else $error("select held after transaction");
  read_cov_c: cover property (@(posedge clk_sys) rd_valid_q && rd_last_q);
  write_cov_c: cover property (@(posedge clk_sys)
    st_q == UBM_END && wr_q);
  sw_rst_cov_c: cover property (@(posedge clk_sys) swc_q == 5'h01);
  ovr_cov_c: cover property (@(posedge clk_sys) $rose(ovr_q));

endmodule // ubm_manager

/* File: rtl/ubm_pkg.sv */
/*
  Types of the utility bus manager.
  Assumes nothing of its surroundings.
*/
package ubm_pkg;

  typedef enum logic [2:0] {
    UBM_IDLE = 3'b000,
    UBM_ALE = 3'b001,
    UBM_ADR = 3'b010,
    UBM_STB = 3'b011,
    UBM_REC = 3'b100,
    UBM_END = 3'b101
  } ubm_state_t;

endpackage

/* File: rtl/ubm_sync.sv */
/*
  Two flip-flop synchroniser for a vector of pin levels.
  Assumes each bit is an independent level from outside the clock domain;
  RST_VAL gives each bit the idle level of its pin.
*/
`timescale 1ns/1ps
module ubm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input logic clk_sys,
  input logic rst_n,
  input logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_chk
    $error("ubm_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // ubm_sync

/* File: sim/tb_phy_utility_bus_manager.sv */
/*
  Bench of the utility bus manager: straps, registers, PHY reset,
  write then read back on every PHY, interrupt and in-band reset.
  Assumes ubm_phy_model stands on the far side of the pins.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end end
module tb_phy_utility_bus_manager;
  logic clk_sys, rst_n, cmd_valid, cmd_ready, cmd_write, wr_valid;
  logic wr_ready, rd_valid, rd_last, busy, inband_reset, reg_wr, reg_rd;
  logic phy_irq, phy_reset_n, phy_interrupt_n, s0o, s0e, rdo, rde, wro;
  logic wre, aleo, alee, p2, p3, sp2, sp3, irq_set, irq_clr;
  logic [3:0] cmd_phy, mode_select;
  logic [4:0] cmd_len_m1;
  logic [7:0] cmd_reg_addr, wr_data, rd_data, reg_wdata, reg_rdata, r;
  logic [7:0] bo, be, bw;
  logic [9:0] tag_straps;
  logic [11:0] mo, me, mi, smb;
  logic [12:0] sel_n;
  logic [15:0] reg_addr;
  logic [7:0] wb [32];
  int checks, n_mismatch, cyc, seed, exp_phy, low_cnt, len;
  // Strap resistors hold released pins
  assign mi = (me & mo) | (~me & smb);
  assign p2 = rde ? rdo : sp2;
  assign p3 = wre ? wro : sp3;
  assign sel_n = {mi, s0e ? s0o : 1'b1};
  ubm_manager u_ubm_manager (.clk_sys, .rst_n, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_phy, .cmd_reg_addr, .cmd_len_m1, .wr_data, .wr_valid,
    .wr_ready, .rd_data, .rd_valid, .rd_last, .busy, .inband_reset,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .mode_select,
    .tag_straps, .phy_irq, .management_bus_pins_in(mi),
    .management_bus_pins_out(mo), .management_bus_pins_oe(me),
    .management_pin_one_out(s0o), .management_pin_one_oe(s0e),
    .management_pin_two_in(p2), .management_pin_two_out(rdo),
    .management_pin_two_oe(rde), .management_pin_three_in(p3),
    .management_pin_three_out(wro), .management_pin_three_oe(wre),
    .management_pin_five_out(aleo), .management_pin_five_oe(alee),
    .management_byte_bus_in(bw), .management_byte_bus_out(bo),
    .management_byte_bus_oe(be), .phy_reset_n, .phy_interrupt_n);
  ubm_phy_model u_ubm_phy_model (.clk_sys, .sel_n, .rd_n(p2), .wr_n(p3),
    .ale(alee & aleo), .bus_out(bo), .bus_oe(be), .irq_set, .irq_clr,
    .bus_w(bw), .phy_interrupt_n);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  always @(negedge clk_sys) begin
    if (rst_n && phy_reset_n === 1'b0) low_cnt++;
    if (alee && aleo) begin
      `CHK("selects", ~(13'h1 << exp_phy), sel_n)
      `CHK("address", cmd_reg_addr, bw)
      `CHK("strobes", 2'b11, {p2, p3})
    end
    if (!p2 && !(&sel_n)) `CHK("release", 8'h00, be)
  end
  task automatic reg_acc(input logic w, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    r = reg_rdata;
  endtask
  task automatic xfer(input logic w, input int phy, input logic [7:0] a);
    int got;
    @(posedge clk_sys);
    cmd_write <= w;
    cmd_phy <= 4'(phy);
    cmd_reg_addr <= a;
    cmd_len_m1 <= 5'(len - 1);
    cmd_valid <= 1'b1;
    wr_valid <= w;
    wr_data <= wb[0];
    exp_phy = phy;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    @(negedge clk_sys);
    `CHK("busy", 1'b1, busy)
    for (got = 0; got < len; ) begin
      @(negedge clk_sys);
      if (w && wr_ready === 1'b1) begin
        @(posedge clk_sys);
        wr_data <= wb[(got + 1) % 32];
        if (got == len - 1) wr_valid <= 1'b0;
        got++;
      end else if (!w && rd_valid === 1'b1) begin
        `CHK("read data", wb[got], rd_data)
        `CHK("last", got == len - 1, rd_last)
        got++;
      end
    end
  endtask
  initial begin
    seed = 32'hce01;
    {rst_n, cmd_valid, cmd_write, wr_valid, inband_reset} = '0;
    {reg_wr, reg_rd, irq_set, irq_clr, reg_addr, reg_wdata} = '0;
    {cmd_phy, cmd_len_m1, cmd_reg_addr, wr_data} = '0;
    smb = 12'($random(seed));
    sp2 = 1'b0;
    sp3 = 1'($random(seed));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    `CHK("power-up phy reset", 8, low_cnt)
    `CHK("straps", smb[9:0], tag_straps)
    `CHK("modes", {sp2, smb[11], sp3, smb[10]}, mode_select)
    reg_acc(1'b0, 16'h801a, 8'h00);
    `CHK("override reset", 1'b0, r[0])
    reg_acc(1'b0, 16'h8100, 8'h00);
    `CHK("unmapped", 8'h00, r)
    reg_acc(1'b1, 16'h8006, 8'h0f);
    `CHK("locked", {sp2, smb[11], sp3, smb[10]}, mode_select)
    reg_acc(1'b1, 16'h801a, 8'h01);
    reg_acc(1'b1, 16'h8006, 8'h08);
    `CHK("utopia mode", 4'h8, mode_select)
    `CHK("pins off", 0, {cmd_ready, me, s0e, rde, wre, alee, be})
    reg_acc(1'b1, 16'h8006, 8'h00);
    low_cnt = 0;
    reg_acc(1'b1, 16'h8007, 8'h01);
    reg_acc(1'b0, 16'h8007, 8'h00);
    `CHK("reset bit busy", 1'b1, r[0])
    repeat (20) @(posedge clk_sys);
    `CHK("phy reset bit", 16, low_cnt)
    reg_acc(1'b0, 16'h8007, 8'h00);
    `CHK("reset bit clear", 1'b0, r[0])
    for (int t = 0; t < 13; t++) begin
      len = (t == 0) ? 32 : (t == 1) ? 1 : {$random(seed)} % 32 + 1;
      foreach (wb[i]) wb[i] = 8'($random(seed));
      r = 8'($random(seed));
      xfer(1'b1, t, r);
      xfer(1'b0, t, r);
    end
    @(posedge clk_sys);
    irq_set <= 1'b1;
    @(posedge clk_sys);
    irq_set <= 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("irq raised", 1'b1, phy_irq)
    @(posedge clk_sys);
    irq_clr <= 1'b1;
    @(posedge clk_sys);
    irq_clr <= 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("irq cleared", 1'b0, phy_irq)
    low_cnt = 0;
    @(posedge clk_sys);
    inband_reset <= 1'b1;
    @(posedge clk_sys);
    inband_reset <= 1'b0;
    @(negedge clk_sys);
    `CHK("inband refuse", 1'b0, cmd_ready)
    repeat (40) @(posedge clk_sys);
    `CHK("inband phy reset", 8, low_cnt)
    `CHK("restrap", smb[9:0], tag_straps)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("irq in reset", 1'b0, phy_irq)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    reg_acc(1'b0, 16'h801a, 8'h00);
    `CHK("override after reset", 1'b0, r[0])
    print_verdict();
  end
endmodule // tb_phy_utility_bus_manager

/* File: sim/ubm_phy_model.sv */
/*
  PHY side of the utility bus: latches the address, stores written
  bytes, returns them on reads and holds an interrupt until cleared.
  Assumes the bench resolves pin levels and feeds bus_w back.
*/
`timescale 1ns/1ps
module ubm_phy_model (
  input wire logic clk_sys,
  input wire logic [12:0] sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe,
  input wire logic irq_set,
  input wire logic irq_clr,
  output logic [7:0] bus_w,
  output logic phy_interrupt_n
);
  logic [7:0] mem [256];
  logic [7:0] adr, cnt, last, bus_p;
  logic ale_p, rd_p, wr_p, drv;
  initial begin
    last = 8'h00;
    phy_interrupt_n = 1'b1;
  end
  // Released bus shows the inverse of its last level
  assign drv = !(&sel_n) && !rd_n;
  assign bus_w = (bus_oe & bus_out)
    | (~bus_oe & (drv ? mem[adr + cnt] : ~last));
  always @(posedge clk_sys) begin
    last <= bus_w;
    bus_p <= bus_w;
    ale_p <= ale;
    rd_p <= rd_n;
    wr_p <= wr_n;
    if (ale_p && !ale) begin
      adr <= bus_p;
      cnt <= 8'h00;
    end
    if (!wr_n && !(&sel_n)) mem[adr + cnt] <= bus_w;
    if ((!wr_p && wr_n) || (!rd_p && rd_n)) cnt <= cnt + 8'h01;
    if (irq_set) phy_interrupt_n <= 1'b0;
    else if (irq_clr) phy_interrupt_n <= 1'b1;
  end
endmodule // ubm_phy_model
